// >>> include/adc_seq_pkg.sv
// constants for the converter sequencer: timing counts, field positions, widths
// assumes a 50 MHz system clock; the minimum prescale and minimum total counts are derived from times in ns
package adc_seq_pkg;
  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int SYS_PERIOD_NS       = 20;
  localparam int CONV_CLK_MIN_NS     = 50;
  localparam int SOC_DELAY_SYS       = 3;
  localparam int SH_CONV_PERIODS     = 3;
  localparam int CONV_CONV_PERIODS   = 10;
  localparam int EOC_FIFO_SYS        = 2;
  localparam int FLAG_INT_SYS        = 2;
  localparam int TOTAL_MIN_NS        = 900;
  // least prescale in system cycles per converter period, rounded up
  localparam int PRESCALE_MIN        = (CONV_CLK_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int TOTAL_MIN_SYS       = (TOTAL_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  // ----------------------------------------
  // widths and fields
  // ----------------------------------------
  localparam int PRE_W               = 4;
  localparam int CNT_W               = 8;
  localparam int CTRL_W              = 16;
  localparam int RES_W               = 10;
  localparam int BIT_START           = 0;
  localparam int BIT_IMM_START       = 13;
  localparam logic [RES_W-1:0] RES_MIN = 10'h000;
  localparam logic [RES_W-1:0] RES_MAX = 10'h3FF;
  localparam logic [PRE_W-1:0] PRESCALE_RESET = 4'h3;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_DELAY = 3'b001,
    ST_SH    = 3'b010,
    ST_CONV  = 3'b011,
    ST_LOAD  = 3'b100
  } seq_state_t;
endpackage

// >>> logic/adc_conversion_sequencer_timing.sv
// start-of-conversion sequencer: start delay, sample/hold, conversion, result load, flag, irq
// assumes all inputs synchronous to clk; the analog stage presents raw_code during conversion
`timescale 1ns/1ps
module adc_conversion_sequencer_timing
  import adc_seq_pkg::*;
(
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rstn,
  // start sources
  input  wire logic [CTRL_W-1:0]       converter_control_first,
  input  wire logic                    start_of_conversion_trigger,
  input  wire logic                    event_manager_conversion_trigger,
  input  wire logic [PRE_W-1:0]        prescale,
  // analog stage
  input  wire logic signed [RES_W+1:0] raw_code,
  output logic                         sample_hold,
  output logic                         converting,
  output logic                         conv_clk,
  // result fifo side
  output logic                         fifo_load,
  output logic [RES_W-1:0]             fifo_data,
  // flag and interrupt
  input  wire logic                    done_clear,
  output logic                         done_flag,
  output logic                         converter_interrupt_request,
  output logic                         busy
);
  // ----------------------------------------
  // trigger and prescale decode
  // ----------------------------------------
  wire logic sw_start = converter_control_first[BIT_IMM_START]
                      | converter_control_first[BIT_START];
  wire logic hw_start = start_of_conversion_trigger
                      | event_manager_conversion_trigger;
  // too small a prescale would push the converter clock under its minimum period
  wire logic [PRE_W-1:0] pre_eff = (prescale < PRE_W'(PRESCALE_MIN))
                                 ? PRE_W'(PRESCALE_MIN) : prescale;

  seq_state_t state;
  seq_state_t next_state;
  logic [PRE_W-1:0] pre_cnt;
  logic [CNT_W-1:0] step_cnt;
  logic [CNT_W-1:0] total_cnt;
  logic [1:0]       int_cnt;
  logic [RES_W-1:0] held_code;
  wire  logic [RES_W-1:0] sat_code;

  adc_saturate u_sat (
    .raw  (raw_code),
    .code (sat_code)
  );

  wire logic idle   = state == ST_IDLE;
  // ignoring triggers outside idle keeps one result in flight at a time
  wire logic start  = idle & (sw_start | hw_start);
  wire logic tick   = pre_cnt == pre_eff - PRE_W'(1);
  wire logic delay_done = step_cnt == CNT_W'(SOC_DELAY_SYS - 1);
  wire logic sh_done    = tick & (step_cnt == CNT_W'(SH_CONV_PERIODS - 1));
  wire logic conv_done  = tick & (step_cnt == CNT_W'(CONV_CONV_PERIODS - 1));
  // the load waits both the end-of-conversion gap and the overall minimum
  wire logic load_ok = (step_cnt >= CNT_W'(EOC_FIFO_SYS - 1))
                     & (total_cnt >= CNT_W'(TOTAL_MIN_SYS - 1));

  // ----------------------------------------
  // state sequence
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:  if (start) next_state = ST_DELAY;
      ST_DELAY: if (delay_done) next_state = ST_SH;
      ST_SH:    if (sh_done) next_state = ST_CONV;
      ST_CONV:  if (conv_done) next_state = ST_LOAD;
      ST_LOAD:  if (load_ok) next_state = ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
  end

  // phases that run on the converter clock; decoded in more than one place
  function automatic logic conv_phase(input seq_state_t s);
    conv_phase = (s == ST_SH) || (s == ST_CONV);
  endfunction

  wire logic step_clr = (next_state != state);
  // the phase count only moves on converter clock ticks inside sample and conversion
  wire logic step_hold = conv_phase(state) & ~tick;
  wire logic [CNT_W-1:0] next_step_cnt  = step_clr   ? '0
                                        : step_hold  ? step_cnt
                                        : step_cnt + CNT_W'(1);
  // saturating, so a slow prescale can never wrap the total back under its minimum
  wire logic             total_full     = &total_cnt;
  wire logic [CNT_W-1:0] next_total_cnt = idle       ? '0
                                        : total_full ? total_cnt
                                        : total_cnt + CNT_W'(1);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      step_cnt <= '0;
    end else begin
      step_cnt <= next_step_cnt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      total_cnt <= '0;
    end else begin
      total_cnt <= next_total_cnt;
    end
  end

  // ----------------------------------------
  // prescaled converter clock
  // ----------------------------------------
  // restarted on entry to sample so every phase holds whole periods
  wire logic             pre_clr       = (state == ST_IDLE) | (state == ST_DELAY) | tick;
  wire logic [PRE_W-1:0] next_pre_cnt  = pre_clr ? '0 : pre_cnt + PRE_W'(1);
  // an odd prescale leaves the high half one cycle shorter than the low half
  wire logic             next_conv_clk = conv_phase(state) & (pre_cnt < (pre_eff >> 1));

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pre_cnt <= '0;
    end else begin
      pre_cnt <= next_pre_cnt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      conv_clk <= 1'b0;
    end else begin
      conv_clk <= next_conv_clk;
    end
  end

  // ----------------------------------------
  // result, flag and interrupt
  // ----------------------------------------
  wire logic loading          = (state == ST_LOAD) & load_ok;
  wire logic next_sample_hold = next_state == ST_SH;
  wire logic next_converting  = next_state == ST_CONV;
  wire logic next_busy        = next_state != ST_IDLE;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sample_hold <= 1'b0;
      converting  <= 1'b0;
      busy        <= 1'b0;
    end else begin
      sample_hold <= next_sample_hold;
      converting  <= next_converting;
      busy        <= next_busy;
    end
  end

  // caught at the last conversion tick, so later raw changes cannot reach the result
  always_ff @(posedge clk) begin
    if (!rstn) begin
      held_code <= RES_MIN;
    end else if (conv_done) begin
      held_code <= sat_code;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      fifo_load <= 1'b0;
      fifo_data <= RES_MIN;
    end else begin
      fifo_load <= loading;
      if (loading) begin
        fifo_data <= held_code;
      end
    end
  end

  // set wins over a clear in the same cycle
  wire logic       next_done_flag = fifo_load | (done_flag & ~done_clear);
  wire logic       int_full       = &int_cnt;
  wire logic [1:0] next_int_cnt   = !done_flag ? 2'h0
                                  : int_full   ? int_cnt
                                  : int_cnt + 2'h1;
  wire logic       int_due        = int_cnt >= 2'(FLAG_INT_SYS - 1);
  // a flag cleared before the delay runs out never raises the request
  wire logic       next_converter_interrupt_request = done_flag & int_due;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      done_flag <= 1'b0;
    end else begin
      done_flag <= next_done_flag;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      int_cnt <= 2'h0;
    end else begin
      int_cnt <= next_int_cnt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      converter_interrupt_request <= 1'b0;
    end else begin
      converter_interrupt_request <= next_converter_interrupt_request;
    end
  end
endmodule

// >>> logic/adc_saturate.sv
// clamps the analog stage's raw code into the 10-bit result range
// assumes the raw code is signed and may exceed either end of the range
`timescale 1ns/1ps
module adc_saturate
  import adc_seq_pkg::*;
(
  // raw in
  input  wire logic signed [RES_W+1:0] raw,
  // clamped out
  output logic        [RES_W-1:0]      code
);
  wire logic below = raw <= $signed(12'h000);
  wire logic above = raw >= $signed({2'b00, RES_MAX});

  assign code = below ? RES_MIN : above ? RES_MAX : raw[RES_W-1:0];
endmodule

// >>> sim/adc_conversion_sequencer_timing_test.sv
// testbench: one conversion per start source, with clamp, saturation and retrigger
// assumes the sequencer top and its package; inputs change at the falling edge
`timescale 1ns/1ps
module adc_conversion_sequencer_timing_test;
  import adc_seq_pkg::*;
  logic                    clk = 1'b0, rstn = 1'b0, done_clear = 1'b0;
  logic                    start_of_conversion_trigger = 1'b0;
  logic                    event_manager_conversion_trigger = 1'b0;
  logic                    sample_hold, converting, conv_clk, fifo_load;
  logic                    done_flag, converter_interrupt_request, busy;
  logic [CTRL_W-1:0]       converter_control_first = 16'h0000;
  logic [PRE_W-1:0]        prescale = 4'h3;
  logic signed [RES_W+1:0] raw_code = 12'h000;
  logic [RES_W-1:0]        fifo_data;
  int                      mismatches = 0, checked = 0, cyc = 0;
  adc_conversion_sequencer_timing uut (.clk, .rstn, .converter_control_first,
    .start_of_conversion_trigger, .event_manager_conversion_trigger, .prescale, .raw_code,
    .sample_hold, .converting, .conv_clk, .fifo_load, .fifo_data, .done_clear, .done_flag,
    .converter_interrupt_request, .busy);
  initial forever #10 clk = ~clk;
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one conversion; a retrigger while busy must be ignored
  task automatic run_conv(input int src, input logic [PRE_W-1:0] p,
                          input logic signed [RES_W+1:0] raw, input logic [RES_W-1:0] exp);
    int   n, sh, cv, pe, exp_n, rises, last, gap_min;
    logic prev_clk;
    pe = (p < PRE_W'(PRESCALE_MIN)) ? PRESCALE_MIN : int'(p);
    exp_n = SOC_DELAY_SYS + (SH_CONV_PERIODS + CONV_CONV_PERIODS) * pe + EOC_FIFO_SYS;
    if (exp_n < TOTAL_MIN_SYS) begin
      exp_n = TOTAL_MIN_SYS;
    end
    n = 0;
    sh = 0;
    cv = 0;
    rises = 0;
    last = 0;
    gap_min = 1000;
    prev_clk = 1'b0;
    converter_control_first = (src == 0) ? 16'h2000 : (src == 1) ? 16'h0001 : 16'h0000;
    start_of_conversion_trigger = (src == 2);
    event_manager_conversion_trigger = (src == 3);
    prescale = p;
    raw_code = raw;
    @(negedge clk);
    converter_control_first = 16'h0000;
    start_of_conversion_trigger = 1'b0;
    event_manager_conversion_trigger = 1'b0;
    while (fifo_load !== 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
      sh += int'(sample_hold === 1'b1);
      cv += int'(converting === 1'b1);
      if (conv_clk === 1'b1 && prev_clk !== 1'b1) begin
        if (rises > 0 && n - last < gap_min) begin
          gap_min = n - last;
        end
        last = n;
        rises++;
      end
      prev_clk = conv_clk;
      event_manager_conversion_trigger = (n == 10);
    end
    event_manager_conversion_trigger = 1'b0;
    chk(16'(n), 16'(exp_n));
    chk(16'(n >= TOTAL_MIN_SYS), 16'h0001);
    chk(16'(sh), 16'(SH_CONV_PERIODS * pe));
    chk(16'(cv), 16'(CONV_CONV_PERIODS * pe));
    chk(16'(rises), 16'(SH_CONV_PERIODS + CONV_CONV_PERIODS));
    chk(16'(gap_min), 16'(pe));
    chk(16'(fifo_data), 16'(exp));
    @(negedge clk);
    chk(16'({done_flag, converter_interrupt_request}), 16'h0002);
    @(negedge clk);
    chk(16'(converter_interrupt_request), 16'h0000);
    @(negedge clk);
    chk(16'({converter_interrupt_request, busy}), 16'h0002);
    done_clear = 1'b1;
    @(negedge clk);
    done_clear = 1'b0;
    repeat (2) @(negedge clk);
    chk(16'({done_flag, converter_interrupt_request, busy}), 16'h0000);
  endtask
  task automatic scen_imm_start();
    run_conv(0, 4'h0, -12'sh005, 10'h000);
  endtask
  task automatic scen_ctrl_start();
    run_conv(1, 4'h3, 12'sh500, 10'h3FF);
  endtask
  task automatic scen_pin_start();
    run_conv(2, 4'h5, 12'sh123, 10'h123);
  endtask
  task automatic scen_event_start();
    run_conv(3, 4'h3, 12'sh3FF, 10'h3FF);
  endtask
  // a clear held across the load: the set wins for one cycle and no request follows
  task automatic scen_clear_race();
    int n;
    n = 0;
    done_clear = 1'b1;
    start_of_conversion_trigger = 1'b1;
    @(negedge clk);
    start_of_conversion_trigger = 1'b0;
    while (fifo_load !== 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    chk(16'(n), 16'(TOTAL_MIN_SYS));
    @(negedge clk);
    chk(16'(done_flag), 16'h0001);
    @(negedge clk);
    chk(16'({done_flag, converter_interrupt_request}), 16'h0000);
    repeat (2) @(negedge clk);
    chk(16'(converter_interrupt_request), 16'h0000);
    done_clear = 1'b0;
  endtask
  // ----------------------------------------
  // main sequence and hang guard
  // ----------------------------------------
  initial begin
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    scen_imm_start();
    scen_ctrl_start();
    scen_pin_start();
    scen_event_start();
    scen_clear_race();
    print_verdict();
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 5000) begin
      mismatches++;
      print_verdict();
    end
  end
endmodule

// >>> sim/adc_seq_props.sv
// checker: phase order and minimum delays of the conversion sequencer
// assumes it is bound to the sequencer top; all figures in 20 ns system cycles
`timescale 1ns/1ps
module adc_seq_props
  import adc_seq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // observed outputs
  input wire logic sample_hold,
  input wire logic converting,
  input wire logic fifo_load,
  input wire logic done_flag,
  input wire logic converter_interrupt_request,
  input wire logic busy
);
  // ----------------------------------------
  // cycles spent busy, for the total time
  // ----------------------------------------
  logic [7:0] span;
  logic [7:0] conv_run;
  always_ff @(posedge clk) begin
    if (!rstn || !busy) span <= 8'h00;
    else                span <= span + 8'h01;
  end
  // cycles spent converting; ten periods are too long to write out as a repetition
  always_ff @(posedge clk) begin
    if (!rstn || !converting) conv_run <= 8'h00;
    else                      conv_run <= conv_run + 8'h01;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  chk_sh_length: assert property ($rose(sample_hold) |-> sample_hold[*8] ##1 sample_hold)
    else $error("sample hold too short");
  chk_conv_follows: assert property ($fell(sample_hold) |-> converting)
    else $error("conversion does not follow sample hold");
  chk_conv_length: assert property ($fell(converting) |->
    conv_run >= 8'(CONV_CONV_PERIODS * PRESCALE_MIN))
    else $error("conversion too short");
  chk_start_delay: assert property ($rose(busy) |-> !sample_hold[*3])
    else $error("sample hold began too soon");
  chk_load_gap: assert property ($fell(converting) |-> !fifo_load[*2])
    else $error("result loaded too soon");
  chk_irq_delay: assert property ($rose(done_flag) |-> !converter_interrupt_request[*2])
    else $error("interrupt raised too soon");
  chk_irq_follows: assert property (done_flag[*3] |-> converter_interrupt_request)
    else $error("interrupt missing after flag");
  chk_total_time: assert property (fifo_load |-> span >= 8'(TOTAL_MIN_SYS))
    else $error("trigger to load under 900 ns");
  chk_flag_set: assert property (fifo_load |=> done_flag && !fifo_load)
    else $error("flag not set after load");
  chk_busy_span: assert property (sample_hold || converting |-> busy)
    else $error("phase active while idle");
endmodule
bind adc_conversion_sequencer_timing adc_seq_props u_props (.clk, .rstn, .sample_hold,
  .converting, .fifo_load, .done_flag, .converter_interrupt_request, .busy);
